// ### blit_line_accel_params.sv
// Function
// - line count field is lines minus one
// - routing bit 7 clear invalidates cache at end
// - routing bit 6 sends results to host
// - transparency with nop background and dest-free foreground uses mix bits as byte enables
// - mix enable: mix from host or memory
// - mix disabled, no host mix: mix is one
// - host route field: unused, source, mix, reserved
// - mix zero bytes use background rop code
// - mix one bytes use foreground rop code
// - destination field is first byte address
// - mix address is a bit address
// - line change sets mix pointer to line base plus offset+1
// - error term only seeds line engine error
// - line start loads error from queue or major
// - pixel depth decodes to one to four bytes
`timescale 1ns/100ps
`default_nettype none
module blit_line_accel_params
  import blit_params_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  output logic host_rvalid,
  input wire blit_params_pkg::pixel_depth_t pixel_depth,
  input wire logic line_op,
  input wire logic error_from_queue,
  input wire logic op_start,
  input wire logic byte_step,
  input wire logic line_step,
  input wire logic op_end,
  input wire logic [7:0] src_byte,
  input wire logic [7:0] pat_byte,
  input wire logic [7:0] dst_byte,
  input wire logic mix_bit_in,
  output logic [7:0] result_byte,
  output logic result_write_en,
  output logic result_valid,
  output logic dest_read_needed,
  output logic mix_from_host,
  output logic mix_from_memory,
  output logic host_is_source,
  output logic result_to_host,
  output logic cache_invalidate,
  output logic [11:0] lines_remaining,
  output logic last_line,
  output logic [21:0] dest_byte_ptr,
  output logic [24:0] mix_bit_ptr,
  output logic [15:0] bresenham_error,
  output logic [2:0] bytes_per_pixel
);
  import blit_params_pkg::*;

  typedef struct packed {
    // queued registers as the host sees them
    logic [15:0] line_count;
    logic [7:0] routing_control;
    logic [7:0] background_rop;
    logic [7:0] foreground_rop;
    logic [31:0] destination_address;
    logic [31:0] mix_address;
    logic [15:0] mix_line_offset;
    logic [15:0] line_error_term;
    logic [15:0] line_minor_delta;
    logic [15:0] line_major_delta;
    // host read answer
    logic [7:0] rdata;
    logic rvalid;
    // per-byte result
    logic [7:0] result;
    logic wen;
    logic rvld;
    // routing decode
    logic dest_rd;
    logic mix_host;
    logic mix_mem;
    logic host_src;
    logic to_host;
    logic inval;
    // operation state
    logic [CNT_W-1:0] lines_left;
    logic last;
    logic [DEST_W-1:0] dest_ptr;
    logic [MIX_W-1:0] mix_ptr;
    logic [MIX_W-1:0] mix_base;
    logic [ERR_W-1:0] err;
    logic [2:0] bpp;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  // raster op: bit index is {pattern, source, destination}
  // one table lookup per bit lane; each code gets its own lookup and the mix bit picks one
  function automatic logic [7:0] rop_apply(input logic [7:0] code,
      input logic [7:0] p, input logic [7:0] s, input logic [7:0] d);
    logic [7:0] r;
    r = ZERO_BYTE;
    for (int i = 0; i < 8; i++) begin
      r[i] = code[{p[i], s[i], d[i]}];
    end
    return r;
  endfunction

  // a code ignores destination when odd and even table bits agree
  function automatic logic rop_uses_dest(input logic [7:0] code);
    return {code[7], code[5], code[3], code[1]} !=
           {code[6], code[4], code[2], code[0]};
  endfunction

  // byte write into a wider register, reserved bits masked off
  function automatic logic [31:0] put_byte(input logic [31:0] cur,
      input logic [1:0] lane, input logic [7:0] b, input logic [31:0] m);
    logic [31:0] v;
    v = cur;
    v[lane*8 +: 8] = b;
    return v & m;
  endfunction

  // helpers, each given a value on every pass
  host_route_t route;
  logic transp;
  logic mix_eff;
  logic [31:0] rd_word;
  logic [1:0] lane;
  logic [7:0] rd_byte;

  always_comb begin
    s_nxt = s_r;
    route = host_route_t'(s_r.routing_control[HOST_ROUTE_HI:HOST_ROUTE_LO]);
    lane = host_addr[1:0];
    rd_word = 32'h0000_0000;
    rd_byte = ZERO_BYTE;

    // register writes; only architected bits are kept
    if (host_wr) begin
      unique case ({host_addr[7:1], 1'b0})
        ADDR_LINE_COUNT: s_nxt.line_count = 16'(put_byte(
            {16'h0000, s_r.line_count}, {1'b0, host_addr[0]},
            host_wdata, {16'h0000, MASK_12}));
        ADDR_ROUTING: if (!host_addr[0]) begin
          s_nxt.routing_control = host_wdata & MASK_ROUTING;
        end
        // both rop codes share one halfword slot
        ADDR_BG_ROP: if (host_addr[0]) begin
          s_nxt.foreground_rop = host_wdata;
        end else begin
          s_nxt.background_rop = host_wdata;
        end
        ADDR_DEST, ADDR_DEST + 8'h02: s_nxt.destination_address =
            put_byte(s_r.destination_address, lane, host_wdata,
            MASK_DEST);
        ADDR_MIX, ADDR_MIX + 8'h02: s_nxt.mix_address =
            put_byte(s_r.mix_address, lane, host_wdata, MASK_MIX);
        ADDR_MIX_OFF: s_nxt.mix_line_offset = 16'(put_byte(
            {16'h0000, s_r.mix_line_offset}, {1'b0, host_addr[0]},
            host_wdata, {16'h0000, MASK_12}));
        ADDR_ERROR: s_nxt.line_error_term = 16'(put_byte(
            {16'h0000, s_r.line_error_term}, {1'b0, host_addr[0]},
            host_wdata, {16'h0000, MASK_16}));
        ADDR_MINOR: s_nxt.line_minor_delta = 16'(put_byte(
            {16'h0000, s_r.line_minor_delta}, {1'b0, host_addr[0]},
            host_wdata, {16'h0000, MASK_12}));
        ADDR_MAJOR: s_nxt.line_major_delta = 16'(put_byte(
            {16'h0000, s_r.line_major_delta}, {1'b0, host_addr[0]},
            host_wdata, {16'h0000, MASK_12}));
        default: ;
      endcase
    end

    // reads answer one cycle later; unmapped bytes read as zero
    unique case ({host_addr[7:2], 2'b00})
      // low half of this word is the x count, kept by another block
      {ADDR_LINE_COUNT[7:2], 2'b00}: rd_word = {s_r.line_count, 16'h0000};
      ADDR_ROUTING: rd_word = {s_r.foreground_rop, s_r.background_rop,
                               8'h00, s_r.routing_control};
      ADDR_DEST: rd_word = s_r.destination_address;
      ADDR_MIX: rd_word = s_r.mix_address;
      ADDR_MIX_OFF: rd_word = {s_r.line_error_term, s_r.mix_line_offset};
      ADDR_MINOR: rd_word = {s_r.line_major_delta, s_r.line_minor_delta};
      default: rd_word = 32'h0000_0000;
    endcase
    rd_byte = rd_word[lane*8 +: 8];
    s_nxt.rvalid = host_rd;
    if (host_rd) begin
      s_nxt.rdata = rd_byte;
    end

    // routing decode, held as flops for the datapath
    s_nxt.to_host = s_r.routing_control[BIT_RESULT_ROUTE];
    s_nxt.host_src = (route == HOST_SOURCE);
    s_nxt.mix_host = (route == HOST_MIX);
    s_nxt.mix_mem = s_r.routing_control[BIT_MIX_EN] &&
                    (route != HOST_MIX);
    // dest read is skipped only when no code can need it
    transp = s_r.routing_control[BIT_TRANSP] &&
             (s_r.background_rop == ROP_NOP) &&
             !rop_uses_dest(s_r.foreground_rop);
    s_nxt.dest_rd = !transp;

    // pixel depth decode
    // held in a flop so the byte counter sees a settled value
    unique case (pixel_depth)
      DEPTH_1: s_nxt.bpp = 3'h1;
      DEPTH_2: s_nxt.bpp = 3'h2;
      DEPTH_3: s_nxt.bpp = 3'h3;
      DEPTH_4: s_nxt.bpp = 3'h4;
    endcase

    // per-byte mix select; without a mix source every byte is foreground
    mix_eff = (s_nxt.mix_host || s_nxt.mix_mem) ? mix_bit_in : 1'b1;
    s_nxt.rvld = byte_step;
    if (byte_step) begin
      s_nxt.result = mix_eff ?
          rop_apply(s_r.foreground_rop, pat_byte, src_byte, dst_byte) :
          rop_apply(s_r.background_rop, pat_byte, src_byte,
                    dst_byte);
      // in transparent mode the mix bit gates the write, dst unread
      s_nxt.wen = transp ? mix_eff : 1'b1;
      s_nxt.dest_ptr = s_r.dest_ptr + 1'b1;
      s_nxt.mix_ptr = s_r.mix_ptr + 1'b1;
    end

    // line change: mix base steps by offset plus one bit
    // a step in the start cycle is dropped, start reloads the line count and pointers
    if (line_step && !op_start) begin
      // the base keeps the line start, the pointer runs per byte
      s_nxt.mix_base = s_r.mix_base + MIX_W'(s_r.mix_line_offset[CNT_W-1:0])
                       + 1'b1;
      s_nxt.mix_ptr = s_nxt.mix_base;
      // count holds at zero so a stray extra step cannot wrap
      if (s_r.lines_left != '0) begin
        s_nxt.lines_left = s_r.lines_left - 1'b1;
      end
    end
    s_nxt.last = (s_nxt.lines_left == '0);

    // operation start seeds pointers, line count and line error
    if (op_start) begin
      s_nxt.lines_left = s_r.line_count[CNT_W-1:0];
      s_nxt.last = (s_r.line_count[CNT_W-1:0] == '0);
      s_nxt.dest_ptr = s_r.destination_address[DEST_W-1:0];
      s_nxt.mix_ptr = s_r.mix_address[MIX_W-1:0];
      s_nxt.mix_base = s_r.mix_address[MIX_W-1:0];
      // block transfers never touch the error term
      if (line_op) begin
        s_nxt.err = error_from_queue ? s_r.line_error_term :
                    s_r.line_major_delta;
      end
    end

    // one-cycle invalidate strobe unless disabled
    // a pulse, so the cache side acts once per operation
    s_nxt.inval = op_end && !s_r.routing_control[BIT_INVAL_DIS];
  end

  // all state registers together
  // reset clears the queue; software reloads it before a start
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // every output is a flop of the state word
  assign host_rdata = s_r.rdata;
  assign host_rvalid = s_r.rvalid;

  // per-byte result
  assign result_byte = s_r.result;
  assign result_write_en = s_r.wen;
  assign result_valid = s_r.rvld;

  // routing decode
  assign dest_read_needed = s_r.dest_rd;
  assign mix_from_host = s_r.mix_host;
  assign mix_from_memory = s_r.mix_mem;
  assign host_is_source = s_r.host_src;
  assign result_to_host = s_r.to_host;
  assign cache_invalidate = s_r.inval;

  // operation state
  assign lines_remaining = s_r.lines_left;
  assign last_line = s_r.last;
  assign dest_byte_ptr = s_r.dest_ptr;
  assign mix_bit_ptr = s_r.mix_ptr;
  assign bresenham_error = s_r.err;
  assign bytes_per_pixel = s_r.bpp;
endmodule // blit_line_accel_params
`default_nettype wire

// ### blit_params_pkg.sv
`default_nettype none
package blit_params_pkg;
  // byte addresses of the queued registers, multi-byte ones little endian
  localparam logic [7:0] ADDR_LINE_COUNT = 8'h9a;
  localparam logic [7:0] ADDR_ROUTING = 8'h9c;
  localparam logic [7:0] ADDR_BG_ROP = 8'h9e;
  localparam logic [7:0] ADDR_FG_ROP = 8'h9f;
  localparam logic [7:0] ADDR_DEST = 8'ha0;
  localparam logic [7:0] ADDR_MIX = 8'ha4;
  localparam logic [7:0] ADDR_MIX_OFF = 8'ha8;
  localparam logic [7:0] ADDR_ERROR = 8'haa;
  localparam logic [7:0] ADDR_MINOR = 8'hac;
  localparam logic [7:0] ADDR_MAJOR = 8'hae;
  // writable-bit masks; everything else is reserved
  localparam logic [15:0] MASK_12 = 16'h0fff;
  localparam logic [15:0] MASK_16 = 16'hffff;
  localparam logic [7:0] MASK_ROUTING = 8'hdb;
  localparam logic [31:0] MASK_DEST = 32'h003f_ffff;
  localparam logic [31:0] MASK_MIX = 32'h01ff_ffff;
  // routing-control field positions
  localparam int BIT_INVAL_DIS = 7;
  localparam int BIT_RESULT_ROUTE = 6;
  localparam int BIT_TRANSP = 4;
  localparam int BIT_MIX_EN = 3;
  localparam int HOST_ROUTE_HI = 1;
  localparam int HOST_ROUTE_LO = 0;
  localparam int DEST_W = 22;
  localparam int MIX_W = 25;
  localparam int CNT_W = 12;
  localparam int ERR_W = 16;
  localparam logic [7:0] ROP_NOP = 8'haa;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] ONES_BYTE = 8'hff;
  typedef enum logic [1:0] {
    HOST_UNUSED = 2'h0,
    HOST_SOURCE = 2'h1,
    HOST_MIX = 2'h2,
    HOST_RESVD = 2'h3
  } host_route_t;
  typedef enum logic [1:0] {
    DEPTH_1 = 2'h0,
    DEPTH_2 = 2'h1,
    DEPTH_3 = 2'h2,
    DEPTH_4 = 2'h3
  } pixel_depth_t;
endpackage
`default_nettype wire

// ### blit_line_accel_params_checker.sv
`timescale 1ns/100ps
`default_nettype none
module blit_params_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic host_rd,
  input wire logic op_start,
  input wire logic byte_step,
  input wire logic line_step,
  input wire logic op_end,
  input wire logic host_rvalid,
  input wire logic result_valid,
  input wire logic result_write_en,
  input wire logic dest_read_needed,
  input wire logic mix_from_host,
  input wire logic mix_from_memory,
  input wire logic host_is_source,
  input wire logic cache_invalidate,
  input wire logic [11:0] lines_remaining,
  input wire logic [21:0] dest_byte_ptr,
  input wire logic [24:0] mix_bit_ptr
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // read answer comes exactly one edge after the strobe
  AST_RD_ANSWER: assert property (host_rd |=> host_rvalid)
    else $error("read not answered");
  AST_RD_NONE: assert property (!host_rd |=> !host_rvalid)
    else $error("spurious read answer");
  AST_ROUTE_EXCL: assert property (mix_from_host |-> !host_is_source)
    else $error("host data routed twice");
  AST_MIX_SRC: assert property (mix_from_host |-> !mix_from_memory)
    else $error("mix taken from two places");
  AST_INVAL: assert property (cache_invalidate |-> $past(op_end))
    else $error("invalidate without operation end");
  AST_DEST_STEP: assert property (byte_step && !op_start |=>
    dest_byte_ptr == $past(dest_byte_ptr) + 22'h00_0001)
    else $error("destination pointer step wrong");
  AST_MIX_STEP: assert property (byte_step && !line_step && !op_start |=>
    mix_bit_ptr == $past(mix_bit_ptr) + 25'h000_0001)
    else $error("mix pointer step wrong");
  AST_LINES: assert property (line_step && !op_start &&
    lines_remaining != 12'h000 |=>
    lines_remaining == $past(lines_remaining) - 12'h001)
    else $error("line count step wrong");
  AST_RESULT: assert property (byte_step |=> result_valid)
    else $error("result missing");
  // opaque mode must write every byte
  AST_WEN: assert property (result_valid && dest_read_needed |->
    result_write_en) else $error("byte masked outside transparency");
endmodule // blit_params_checker
bind blit_line_accel_params blit_params_checker i_blit_params_checker (
  .mclk, .rst, .host_rd, .op_start, .byte_step, .line_step, .op_end,
  .host_rvalid, .result_valid, .result_write_en, .dest_read_needed,
  .mix_from_host, .mix_from_memory, .host_is_source, .cache_invalidate,
  .lines_remaining, .dest_byte_ptr, .mix_bit_ptr);
`default_nettype wire

// ### blit_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module blit_host_model (
  input wire logic mclk,
  output logic [7:0] host_addr,
  output logic host_wr,
  output logic host_rd,
  output logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata,
  input wire logic host_rvalid
);
  initial begin
    host_addr = 8'h00;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_wdata = 8'h00;
  end
  // idle data is inverted so a stale byte never passes for a live one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) #1;
    host_addr = a;
    host_wdata = d;
    host_wr = 1'b1;
    @(posedge mclk) #1;
    host_wr = 1'b0;
    host_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [8:0] r);
    @(posedge mclk) #1;
    host_addr = a;
    host_rd = 1'b1;
    @(posedge mclk) #1;
    host_rd = 1'b0;
    r = {host_rvalid, host_rdata};
  endtask
endmodule // blit_host_model
`default_nettype wire

// ### blit_line_accel_params_tb.sv
`timescale 1ns/100ps
`default_nettype none
module blit_line_accel_params_tb;
  import blit_params_pkg::*;
  logic mclk, rst, line_op, error_from_queue, op_start, byte_step;
  logic line_step, op_end, mix_bit_in, host_wr, host_rd, host_rvalid;
  logic result_write_en, result_valid, dest_read_needed, mix_from_host;
  logic mix_from_memory, host_is_source, result_to_host, cache_invalidate;
  logic last_line;
  logic [7:0] host_addr, host_wdata, host_rdata, src_byte, pat_byte;
  logic [7:0] dst_byte, result_byte;
  logic [11:0] lines_remaining;
  logic [21:0] dest_byte_ptr;
  logic [24:0] mix_bit_ptr;
  logic [15:0] bresenham_error;
  logic [2:0] bytes_per_pixel;
  pixel_depth_t pixel_depth;
  int err_count = 0;
  int checks_done = 0;
  logic [8:0] r;
  // writable masks of 9a..b0, b0 being unmapped
  logic [7:0] msk [23] = '{8'hff, 8'h0f, 8'hdb, 8'h00, 8'hff, 8'hff,
    8'hff, 8'hff, 8'h3f, 8'h00, 8'hff, 8'hff, 8'hff, 8'h01, 8'hff, 8'h0f,
    8'hff, 8'hff, 8'hff, 8'h0f, 8'hff, 8'h0f, 8'h00};
  // 3 lines, dest 100, mix 10, offset 3, error 1234, minor 3, major 5
  logic [15:0] cfg [21] = '{16'h9a02, 16'h9b00, 16'h9c00, 16'h9ecc,
    16'h9ff0, 16'ha000, 16'ha101, 16'ha200, 16'ha300, 16'ha410, 16'ha500,
    16'ha600, 16'ha700, 16'ha803, 16'ha900, 16'haa34, 16'hab12, 16'hac03,
    16'had00, 16'hae05, 16'haf00};
  blit_line_accel_params i_blit_line_accel_params (.mclk, .rst, .host_addr,
    .host_wr, .host_rd, .host_wdata, .host_rdata, .host_rvalid, .pixel_depth,
    .line_op, .error_from_queue, .op_start, .byte_step, .line_step, .op_end,
    .src_byte, .pat_byte, .dst_byte, .mix_bit_in, .result_byte,
    .result_write_en, .result_valid, .dest_read_needed, .mix_from_host,
    .mix_from_memory, .host_is_source, .result_to_host, .cache_invalidate,
    .lines_remaining, .last_line, .dest_byte_ptr, .mix_bit_ptr,
    .bresenham_error, .bytes_per_pixel);
  blit_host_model i_blit_host_model (.mclk, .host_addr, .host_wr, .host_rd,
    .host_wdata, .host_rdata, .host_rvalid);
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // one sequencer event {start, byte, line, end}, outputs settled after
  task automatic ev(input logic [3:0] p);
    @(posedge mclk) #1;
    {op_start, byte_step, line_step, op_end} = p;
    @(posedge mclk) #1;
    {op_start, byte_step, line_step, op_end} = 4'h0;
  endtask
  task automatic settle();
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #20000;
    err_count++;
    results();
  end
  initial begin
    {rst, line_op, error_from_queue, op_start, byte_step} = 5'h18;
    {line_step, op_end, mix_bit_in} = 3'h0;
    {src_byte, pat_byte, dst_byte} = 24'h3c_5a99;
    pixel_depth = DEPTH_1;
    repeat (10) @(posedge mclk);
    #1;
    rst = 1'b0;
    // reset value, then all ones against the writable mask
    for (int i = 0; i < 23; i++) begin
      i_blit_host_model.rd(8'h9a + 8'(i), r);
      chk(r, {1'b1, 8'h00});
      i_blit_host_model.wr(8'h9a + 8'(i), 8'hff);
      i_blit_host_model.rd(8'h9a + 8'(i), r);
      chk(r, {1'b1, msk[i]});
    end
    for (int c = 0; c < 8; c++) begin
      i_blit_host_model.wr(ADDR_ROUTING, {1'b0, c[0], 2'b0, c[2], 1'b0,
        c[1:0]});
      settle();
      chk({mix_from_host, mix_from_memory, host_is_source, result_to_host},
        {c[1:0] == 2, c[2] && c[1:0] != 2, c[1:0] == 1, c[0]});
    end
    for (int d = 0; d < 4; d++) begin
      pixel_depth = pixel_depth_t'(d);
      settle();
      chk(bytes_per_pixel, d + 1);
      // six pixels: five pixels' worth of count, plus one pixel more
      chk(5 * bytes_per_pixel + bytes_per_pixel, 6 * (d + 1));
    end
    // minor axis is the closer one, cache left for invalidation
    // minor 3 on the closer axis, major 5 on the farther one
    foreach (cfg[i]) begin
      i_blit_host_model.wr(cfg[i][15:8], cfg[i][7:0]);
    end
    settle();
    ev(4'h8);
    chk({dest_byte_ptr, mix_bit_ptr}, {22'h100, 25'h10});
    chk({lines_remaining, last_line, bresenham_error},
      {12'h2, 1'b0, 16'h5});
    ev(4'h4);
    chk({result_valid, result_write_en, result_byte}, 10'h35a);
    chk({dest_byte_ptr, mix_bit_ptr}, {22'h101, 25'h11});
    ev(4'h2);
    chk({lines_remaining, mix_bit_ptr}, {12'h1, 25'h14});
    ev(4'h2);
    chk({last_line, lines_remaining, mix_bit_ptr},
      {1'b1, 12'h0, 25'h18});
    ev(4'h1);
    chk(cache_invalidate, 1'b1);
    // host mix of zero selects the background code
    i_blit_host_model.wr(ADDR_ROUTING, 8'h02);
    error_from_queue = 1'b1;
    settle();
    ev(4'h8);
    chk(bresenham_error, 16'h1234);
    ev(4'h4);
    chk({dest_read_needed, result_write_en, result_byte}, 10'h33c);
    // transparent: nop background, pattern-only foreground, cache kept
    i_blit_host_model.wr(ADDR_BG_ROP, ROP_NOP);
    i_blit_host_model.wr(ADDR_ROUTING, 8'h9a);
    settle();
    ev(4'h4);
    chk({dest_read_needed, result_write_en}, 2'b00);
    // a set mix bit opens the write and picks the foreground
    mix_bit_in = 1'b1;
    ev(4'h4);
    chk({dest_read_needed, result_write_en, result_byte}, 10'h15a);
    ev(4'h1);
    chk(cache_invalidate, 1'b0);
    // a block transfer start leaves the error term alone
    {line_op, error_from_queue} = 2'b00;
    ev(4'h8);
    chk(bresenham_error, 16'h1234);
    results();
  end
endmodule // blit_line_accel_params_tb
`default_nettype wire
